// file: hw/spi_unit.sv
// SPI serial unit: pad control, shift engine, buffers and receive FIFO
//
// Summary of operation
// - Unit owns pad direction and value per role.
// - Master drives select only when hardware enabled.
// - Disabled receiver releases its data-in pad.
// - Pull and drive-strength settings pass to pads.
// - Pad placement chosen by in/out select fields.
// - One transmit holding buffer, two receive buffers.
// - Full duplex over four wires.
// - All four clock polarity and phase modes.
// - Selectable LSB-first or MSB-first order.
// - One-direction transfer frees an unused data pad.
// - Master clock from baud generator; slave address qualifies.
// - Slave compares first character with 8-bit address.
// - Slave wakes system on select level change.
// - Keeps working while clocked; requests wake system.
// - Register state and shift logic on unit clock.
// - Configuration writes take effect after synchronisation.
// - Keeps running under debug halt by default.
// - Debug halt select freezes the baud generator.
// - Protection never blocks data or status writes.
// - Debugger accesses bypass write protection.
// - Request lines let DMA service data transfers.
`default_nettype none

// --------------------------------------------------------------------
// Generic FIFO
// --------------------------------------------------------------------
module spi_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,     // unit clock
	input  wire logic             sys_rst,   // async reset, high
	input  wire logic             in_valid,  // write request
	output logic                  in_ready,  // space available
	input  wire logic [WIDTH-1:0] in_data,   // write word
	output logic                  out_valid, // word available
	input  wire logic             out_ready, // read accept
	output logic      [WIDTH-1:0] out_data   // head word
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	wire              do_wr = in_valid && in_ready;
	wire              do_rd = out_valid && out_ready;

	assign in_ready  = count != CW'(DEPTH);
	assign out_valid = count != '0;
	assign out_data  = mem[rd_ptr];

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (do_wr)
				wr_ptr <= bump(wr_ptr);
			if (do_rd)
				rd_ptr <= bump(rd_ptr);
			if (do_wr && !do_rd)
				count <= count + 1'b1;
			else if (do_rd && !do_wr)
				count <= count - 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (do_wr)
			mem[wr_ptr] <= in_data;
	end
endmodule

// --------------------------------------------------------------------
// Top: SPI serial unit
// --------------------------------------------------------------------
module spi_unit
	import spi_unit_pkg::*;
#(
	parameter int QDEPTH = RXQ_DEPTH
) (
	input  wire logic              clock,              // 100 MHz unit clock
	input  wire logic              sys_rst,            // async reset, high
	input  wire cfg_t              cfg_in,             // config write value
	input  wire logic              cfg_write,          // config write strobe
	input  wire logic              peripheral_access_guard, // protect on
	input  wire logic              cfg_from_debugger,  // write by debugger
	input  wire logic              debug_halted,       // CPU halted
	input  wire logic              status_clear,       // clear sticky flags
	input  wire logic [3:0]        pad_pull_enable,    // pad pull setting
	input  wire logic [3:0]        pad_drive_strength, // pad drive setting
	input  wire logic [3:0]        pad_in,             // pad levels
	output logic      [3:0]        pad_out,            // pad drive values
	output logic      [3:0]        pad_oe,             // pad drive enables
	output logic      [3:0]        pad_claim,          // unit owns pad
	output logic      [3:0]        pad_pull,           // pull to pads
	output logic      [3:0]        pad_drive,          // strength to pads
	input  wire logic [CHAR_W-1:0] tx_data,            // transmit character
	input  wire logic              tx_valid,           // transmit request
	output logic                   tx_ready,           // holding empty
	output logic      [CHAR_W-1:0] rx_data,            // received character
	output logic                   rx_valid,           // character ready
	input  wire logic              rx_ready,           // character taken
	output logic                   dma_tx_req,         // DMA may write
	output logic                   dma_rx_req,         // DMA may read
	output status_t                status,             // sticky flags, busy
	output logic                   ss_wake,            // select changed
	output logic                   wake_request        // wake the system
);
	// ----------------------------------------------------------------
	// Configuration synchronisation and protection
	// ----------------------------------------------------------------
	cfg_t        act;
	cfg_t        shadow;
	logic [2:0]  sync_cnt;
	wire         sync_busy  = sync_cnt != '0;
	wire         cfg_accept = cfg_write && !sync_busy &&
		(!peripheral_access_guard || cfg_from_debugger);

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			act      <= CFG_RESET;
			shadow   <= CFG_RESET;
			sync_cnt <= '0;
		end
		else if (cfg_accept)
		begin
			shadow   <= cfg_in;
			sync_cnt <= SYNC_CYCLES;
		end
		else if (sync_busy)
		begin
			sync_cnt <= sync_cnt - 1'b1;
			if (sync_cnt == 3'h1)
				act <= shadow;
		end
	end

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire        master_on = act.enable && act.master;
	wire        slave_on  = act.enable && !act.master;
	wire [5:0]  out_map   = OUT_PAD_MAP[act.data_out_pad_select];
	wire [1:0]  do_idx    = out_map[1:0];
	wire [1:0]  sck_idx   = out_map[3:2];
	wire [1:0]  ss_idx    = out_map[5:4];
	wire [1:0]  di_idx    = act.data_in_pad_select;
	wire        din       = pad_in[di_idx];
	wire        sck_in    = pad_in[sck_idx];
	wire        ss_low    = !pad_in[ss_idx];
	wire        halt      = debug_halted && act.debug_halt_select;

	function automatic logic [4:0] last_edge(input logic c9);
		return c9 ? LAST_EDGE_9 : LAST_EDGE_8;
	endfunction

	function automatic logic [CHAR_W-1:0] rx_align(
		input logic [CHAR_W-1:0] sh, input logic lsb, input logic c9);
		if (c9)
			return sh;
		return lsb ? {1'b0, sh[8:1]} : {1'b0, sh[7:0]};
	endfunction

	// ----------------------------------------------------------------
	// Baud generator and edge events
	// ----------------------------------------------------------------
	xfer_state_t       state;
	logic [7:0]        baud_cnt;
	logic              sck_int;
	logic              sck_prev;
	logic              ss_prev;
	logic [4:0]        k;
	logic [CHAR_W-1:0] tx_sh;
	logic [CHAR_W-1:0] rx_sh;
	logic              hold_full;
	logic [CHAR_W-1:0] hold_data;
	logic              addr_phase;
	logic              accept;
	logic              out_hold;

	wire running   = master_on && state != ST_IDLE;
	wire tick      = running && !halt && baud_cnt == act.baud;
	wire slv_edge  = slave_on && ss_low && sck_in != sck_prev;
	wire slv_start = slave_on && ss_low && !ss_prev;
	wire edge_ev   = master_on ? (tick && state == ST_SHIFT) : slv_edge;
	wire lead      = master_on ? !k[0] : (sck_in != act.cpol);
	wire sample_ev = edge_ev && (lead ^ act.cpha);
	wire setup_ev  = edge_ev && !(lead ^ act.cpha) && k != '0;
	wire end_ev    = edge_ev && k == last_edge(act.char9);
	wire rx_done   = sample_ev &&
		k == last_edge(act.char9) - {4'h0, !act.cpha};
	wire m_load    = master_on && ((state == ST_SELECT && tick) ||
		(end_ev && hold_full));
	wire s_load    = slv_start || (slave_on && end_ev);
	wire load      = m_load || s_load;
	wire tx_bit    = act.lsb_first ? tx_sh[0] :
		(act.char9 ? tx_sh[8] : tx_sh[7]);
	wire [CHAR_W-1:0] rx_shifted = act.lsb_first ?
		{din, rx_sh[8:1]} : {rx_sh[7:0], din};
	wire [CHAR_W-1:0] rx_word = rx_align(rx_shifted, act.lsb_first,
		act.char9);

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			baud_cnt <= '0;
		else if (!running || tick)
			baud_cnt <= '0;
		else if (!halt)
			baud_cnt <= baud_cnt + 1'b1;
	end

	// ----------------------------------------------------------------
	// Master sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			state <= ST_IDLE;
		else if (!master_on)
			state <= ST_IDLE;
		else
			unique case (state)
				ST_IDLE:   if (hold_full) state <= ST_SELECT;
				ST_SELECT: if (tick) state <= ST_SHIFT;
				ST_SHIFT:  if (end_ev && !hold_full) state <= ST_FINISH;
				ST_FINISH: if (tick) state <= ST_IDLE;
			endcase
	end

	// ----------------------------------------------------------------
	// Shift engine
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			k        <= '0;
			sck_int  <= 1'b0;
			sck_prev <= 1'b0;
			ss_prev  <= 1'b0;
			out_hold <= 1'b0;
			tx_sh    <= DATA_RESET;
			rx_sh    <= DATA_RESET;
		end
		else
		begin
			sck_prev <= sck_in;
			ss_prev  <= ss_low;
			// Data pad must not move together with a sampling clock edge
			out_hold <= sample_ev;
			if (master_on && state == ST_SHIFT && edge_ev)
				sck_int <= !sck_int;
			else if (!(master_on && state == ST_SHIFT))
				sck_int <= act.cpol;
			if (end_ev || (slave_on && !ss_low) || state == ST_IDLE)
				k <= '0;
			else if (edge_ev)
				k <= k + 1'b1;
			if (load)
				tx_sh <= hold_full ? hold_data : DATA_RESET;
			else if (setup_ev)
				tx_sh <= act.lsb_first ? tx_sh >> 1 : tx_sh << 1;
			if (sample_ev)
				rx_sh <= rx_shifted;
		end
	end

	// ----------------------------------------------------------------
	// Transmit holding buffer
	// ----------------------------------------------------------------
	assign tx_ready = !hold_full;

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hold_full <= 1'b0;
			hold_data <= DATA_RESET;
		end
		else if (tx_valid && tx_ready)
		begin
			hold_full <= 1'b1;
			hold_data <= tx_data;
		end
		else if (load)
			hold_full <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Address match and receive path
	// ----------------------------------------------------------------
	wire addr_hit = rx_done && slave_on && addr_phase;
	wire rx_push  = rx_done && act.rx_en && !addr_phase && accept;
	logic             buf_ready;
	logic             buf_valid;
	logic [CHAR_W-1:0] buf_data;
	logic             q_ready;

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			addr_phase <= 1'b0;
			accept     <= 1'b1;
		end
		else if (!slave_on)
		begin
			addr_phase <= 1'b0;
			accept     <= 1'b1;
		end
		else if (slv_start)
		begin
			addr_phase <= act.addr_en;
			accept     <= !act.addr_en;
		end
		else if (addr_hit)
		begin
			addr_phase <= 1'b0;
			accept     <= rx_word[7:0] == act.addr_value;
		end
	end

	spi_fifo #(.WIDTH(CHAR_W), .DEPTH(RXBUF_DEPTH)) u_rxbuf (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.in_valid  (rx_push),
		.in_ready  (buf_ready),
		.in_data   (rx_word),
		.out_valid (buf_valid),
		.out_ready (q_ready),
		.out_data  (buf_data)
	);

	spi_fifo #(.WIDTH(CHAR_W), .DEPTH(QDEPTH)) u_rxq (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.in_valid  (buf_valid),
		.in_ready  (q_ready),
		.in_data   (buf_data),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);

	// ----------------------------------------------------------------
	// Status, wake and DMA requests
	// ----------------------------------------------------------------
	wire tx_done = master_on && state == ST_FINISH && tick;

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			status  <= '0;
			ss_wake <= 1'b0;
		end
		else
		begin
			status.rx_overflow <= (rx_push && !buf_ready) ||
				(status.rx_overflow && !status_clear);
			status.tx_complete <= tx_done ||
				(status.tx_complete && !status_clear);
			status.addr_match  <= (addr_hit &&
				rx_word[7:0] == act.addr_value) ||
				(status.addr_match && !status_clear);
			status.sync_busy   <= sync_busy;
			ss_wake <= slave_on && ss_low != ss_prev;
		end
	end

	assign wake_request = ss_wake || rx_valid || status.tx_complete;
	assign dma_tx_req   = act.enable && act.tx_en && !hold_full;
	assign dma_rx_req   = rx_valid;

	// ----------------------------------------------------------------
	// Pad control
	// ----------------------------------------------------------------
	logic [3:0] next_pad_out;
	logic [3:0] next_pad_oe;
	logic [3:0] next_claim;
	wire        ss_hw = master_on && act.master_select_hw_enable;

	always_comb
	begin
		next_pad_out = '0;
		next_pad_oe  = '0;
		next_claim   = '0;
		if (act.enable)
		begin
			next_claim[do_idx]   = act.tx_en;
			next_pad_oe[do_idx]  = act.tx_en;
			next_pad_out[do_idx] = out_hold ? pad_out[do_idx] : tx_bit;
			next_claim[sck_idx]  = 1'b1;
			next_pad_oe[sck_idx] = master_on;
			next_pad_out[sck_idx] = master_on && sck_int;
			next_claim[ss_idx]   = slave_on || ss_hw;
			next_pad_oe[ss_idx]  = ss_hw;
			next_pad_out[ss_idx] = !(ss_hw && state != ST_IDLE);
			next_claim[di_idx]   = act.rx_en;
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pad_out   <= '0;
			pad_oe    <= '0;
			pad_claim <= '0;
			pad_pull  <= '0;
			pad_drive <= '0;
		end
		else
		begin
			pad_out   <= next_pad_out;
			pad_oe    <= next_pad_oe;
			pad_claim <= next_claim;
			pad_pull  <= pad_pull_enable;
			pad_drive <= pad_drive_strength;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_cfg_taken;
		cfg_accept;
	endsequence

	sequence s_sync_wait;
		sync_busy [*3] ##1 !sync_busy;
	endsequence

	a_sync_delay: assert property (@(posedge clock) disable iff (sys_rst)
		s_cfg_taken |=> s_sync_wait)
		else $error("sync busy window wrong");
	a_guard_block: assert property (@(posedge clock) disable iff (sys_rst)
		peripheral_access_guard && !cfg_from_debugger |-> !cfg_accept)
		else $error("protected write accepted");
	a_guard_debug: assert property (@(posedge clock) disable iff (sys_rst)
		cfg_write && cfg_from_debugger && !sync_busy |-> cfg_accept)
		else $error("debugger write refused");
	a_data_open: assert property (@(posedge clock) disable iff (sys_rst)
		tx_valid && !hold_full |=> hold_full && hold_data == $past(tx_data))
		else $error("data write blocked");
	a_debug_freeze: assert property (@(posedge clock) disable iff (sys_rst)
		halt && running ##1 halt && running
		|-> $stable(sck_int) && $stable(baud_cnt))
		else $error("clock moved while frozen");
	a_debug_run: assert property (@(posedge clock) disable iff (sys_rst)
		running && baud_cnt != act.baud && !halt
		|=> baud_cnt == $past(baud_cnt) + 8'h01)
		else $error("clock stalled");
	a_ss_hands_off: assert property (@(posedge clock) disable iff (sys_rst)
		!ss_hw ##1 !ss_hw && $stable(act) |-> !pad_oe[ss_idx])
		else $error("select driven without enable");
	a_rx_release: assert property (@(posedge clock) disable iff (sys_rst)
		act.enable && !act.rx_en && di_idx != do_idx && di_idx != sck_idx
		&& di_idx != ss_idx ##1 $stable(act) |-> !pad_claim[di_idx])
		else $error("data input pad held");
	a_rx_overflow: assert property (@(posedge clock) disable iff (sys_rst)
		rx_push && !buf_ready |=> status.rx_overflow)
		else $error("overflow not flagged");
	a_finish_idle: assert property (@(posedge clock) disable iff (sys_rst)
		tx_done |=> state == ST_IDLE && status.tx_complete)
		else $error("master did not finish");

endmodule
`default_nettype wire

// file: hw/spi_unit_pkg.sv
// Package: configuration, status and constants of the SPI serial unit
`default_nettype none
package spi_unit_pkg;

	// ----------------------------------------------------------------
	// Sizes and counts
	// ----------------------------------------------------------------
	localparam int          CHAR_W      = 9;
	localparam int          RXQ_DEPTH   = 16;
	localparam int          RXBUF_DEPTH = 2;
	localparam logic [2:0]  SYNC_CYCLES = 3'h3;
	localparam logic [4:0]  LAST_EDGE_8 = 5'h0f;
	localparam logic [4:0]  LAST_EDGE_9 = 5'h11;

	// ----------------------------------------------------------------
	// Pad placement: entry {ss, sck, data_out} indexed by out select
	// ----------------------------------------------------------------
	localparam logic [3:0][5:0] OUT_PAD_MAP = {
		6'h1c,	// select 3: ss 1, sck 3, out 0
		6'h27,	// select 2: ss 2, sck 1, out 3
		6'h1e,	// select 1: ss 1, sck 3, out 2
		6'h24	// select 0: ss 2, sck 1, out 0
	};

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       enable;
		logic       master;
		logic       cpol;
		logic       cpha;
		logic       lsb_first;
		logic       char9;
		logic       rx_en;
		logic       tx_en;
		logic       master_select_hw_enable;
		logic [1:0] data_in_pad_select;
		logic [1:0] data_out_pad_select;
		logic [7:0] baud;
		logic       addr_en;
		logic [7:0] addr_value;
		logic       debug_halt_select;
	} cfg_t;

	typedef struct packed {
		logic rx_overflow;
		logic tx_complete;
		logic addr_match;
		logic sync_busy;
	} status_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SELECT = 2'b01,
		ST_SHIFT  = 2'b11,
		ST_FINISH = 2'b10
	} xfer_state_t;

	localparam cfg_t             CFG_RESET  = '0;
	localparam logic [CHAR_W-1:0] DATA_RESET = '0;

endpackage
`default_nettype wire

// file: test/spi_slave_model.sv
// Partner model: external SPI slave hanging on the unit's pads
`default_nettype none
module spi_slave_model (
	input  wire logic       clock, // bench clock
	input  wire logic       ss_n,  // select, low active
	input  wire logic       sck,   // serial clock
	input  wire logic       mosi,  // data from master
	input  wire logic       cpol,  // idle clock level
	input  wire logic       cpha,  // sample on trailing edge
	input  wire logic       lsb,   // least significant bit first
	input  wire logic [7:0] reply, // character sent back
	output logic            miso,  // data to master
	output logic      [7:0] got    // last character taken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	logic [7:0] rx;
	logic [3:0] n;
	logic       skip;
	logic       load;
	logic       drv;
	logic       idle;
	initial
	begin
		{sh, rx, n, skip, load, drv, idle, got} = '0;
	end
	// Released line toggles so a stale level never passes for data
	always @(posedge clock)
		idle <= ~idle;
	assign miso = drv ? (lsb ? sh[0] : sh[7]) : idle;
	always @(negedge ss_n)
	begin
		sh = reply;
		n = 0;
		skip = cpha;
		load = 0;
		drv = 1;
	end
	always @(posedge ss_n)
		drv = 0;
	always @(sck)
		if (!ss_n && ((sck != cpol) != cpha))
		begin
			rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
			n = n + 1;
			load = (n == 8);
			if (load)
				got = rx;
			if (load)
				n = 0;
		end
		else if (!ss_n)
		begin
			if (load)
				sh = reply;
			else if (skip)
				skip = 0;
			else
				sh = lsb ? sh >> 1 : sh << 1;
			load = 0;
		end
endmodule
`default_nettype wire

// file: test/spi_unit_tb_top.sv
// Testbench: SPI unit in master and slave role against a slave model
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; $display("wrong value at %0t: %h %h", $time, a, e); end end
module spi_unit_tb_top import spi_unit_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int QD = 4;
	logic clock, sys_rst, cfg_write, guard, dbg, halted, status_clear;
	logic tx_valid, tx_ready, rx_valid, rx_ready, dma_tx_req, dma_rx_req;
	logic ss_wake, wake_request, miso, tb_ss, idle;
	cfg_t cfg;
	status_t status;
	logic [3:0] pull, drv, pad_in, pad_out, pad_oe, pad_claim;
	logic [3:0] pad_pull, pad_drive;
	logic [8:0] tx_data, rx_data;
	logic [7:0] reply, got;
	int seed, fail_count, compares, k, m, r, i;

	// ----------------------------------------------------------------
	// Clock, pad wiring, design and partner
	// ----------------------------------------------------------------
	initial
	begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	initial
		idle = 0;
	always @(posedge clock)
		idle <= ~idle;
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & {miso, tb_ss, idle, idle});
	spi_unit #(.QDEPTH(QD)) spi_unit_inst (.clock(clock), .sys_rst(sys_rst),
		.cfg_in(cfg), .cfg_write(cfg_write), .peripheral_access_guard(guard),
		.cfg_from_debugger(dbg), .debug_halted(halted),
		.status_clear(status_clear), .pad_pull_enable(pull),
		.pad_drive_strength(drv), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_claim(pad_claim), .pad_pull(pad_pull),
		.pad_drive(pad_drive), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .dma_tx_req(dma_tx_req),
		.dma_rx_req(dma_rx_req), .status(status), .ss_wake(ss_wake),
		.wake_request(wake_request));
	spi_slave_model spi_slave_model_inst (.clock(clock), .ss_n(pad_in[2]),
		.sck(pad_in[1]), .mosi(pad_in[0]), .cpol(cfg.cpol), .cpha(cfg.cpha),
		.lsb(cfg.lsb_first), .reply(reply), .miso(miso), .got(got));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		if (fail_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic to_chk;
		if (k >= 500)
		begin
			fail_count++;
			test_done;
		end
	endtask
	task automatic wcfg(input logic take);
		cfg_write = 1;
		tick(1);
		cfg_write = 0;
		tick(2);
		`CHK(status.sync_busy, take)
		tick(4);
	endtask
	task automatic send(input logic [7:0] b);
		tx_data = {1'b0, b};
		tx_valid = 1;
		for (k = 0; k < 500 && tx_ready !== 1'b1; k++)
			tick(1);
		to_chk;
		tick(1);
		tx_valid = 0;
		tick(1);
	endtask
	task automatic take(input logic [7:0] e);
		for (k = 0; k < 500 && rx_valid !== 1'b1; k++)
			tick(1);
		to_chk;
		`CHK(rx_data[7:0], e)
		`CHK(dma_rx_req, 1'b1)
		rx_ready = 1;
		tick(1);
		rx_ready = 0;
		tick(1);
	endtask
	task automatic master_cfg;
		cfg = '0;
		cfg.enable = 1;
		cfg.master = 1;
		cfg.rx_en = 1;
		cfg.tx_en = 1;
		cfg.master_select_hw_enable = 1;
		cfg.data_in_pad_select = 2'h3;
		cfg.baud = 8'h01;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		seed = 6;
		fail_count = 0;
		compares = 0;
		{cfg_write, guard, dbg, halted, status_clear, rx_ready, tx_valid} = '0;
		{cfg, tx_data, pull, drv, reply} = '0;
		sys_rst = 1;
		tb_ss = 1;
		tick(20);
		`CHK({tx_ready, rx_valid, pad_oe}, 6'h20)
		sys_rst = 0;
		tick(1);
		// Every clock mode in both bit orders, protection on
		for (m = 0; m < 8; m++)
		begin
			pull = $random(seed);
			drv = $random(seed);
			reply = $random(seed);
			i = $random(seed);
			guard = 1;
			dbg = 1;
			halted = m[0];
			master_cfg;
			{cfg.cpol, cfg.cpha, cfg.lsb_first} = m[2:0];
			wcfg(1);
			dbg = 0;
			`CHK(pad_oe, 4'h7)
			`CHK(pad_claim, 4'hf)
			`CHK({pad_pull, pad_drive}, {pull, drv})
			`CHK(pad_out[2:1], {1'b1, cfg.cpol})
			send(i[7:0]);
			send(i[15:8]);
			take(reply);
			take(reply);
			`CHK(got, i[15:8])
			tick(10);
		end
		// Protected write from software is dropped
		cfg.tx_en = 0;
		wcfg(0);
		`CHK(pad_oe, 4'h7)
		// Neither direction, software select
		guard = 0;
		cfg.rx_en = 0;
		cfg.master_select_hw_enable = 0;
		wcfg(1);
		`CHK(pad_oe, 4'h2)
		`CHK(pad_claim, 4'h2)
		`CHK(dma_tx_req, 1'b0)
		// Frozen generator, then fill the receive path past full
		master_cfg;
		cfg.debug_halt_select = 1;
		halted = 1;
		wcfg(1);
		status_clear = 1;
		tick(1);
		status_clear = 0;
		send(8'h5a);
		tick(60);
		`CHK(status.tx_complete, 1'b0)
		halted = 0;
		for (m = 0; m < 7; m++)
			send(m[7:0]);
		tick(100);
		`CHK(status.rx_overflow, 1'b1)
		`CHK(wake_request, 1'b1)
		for (r = 0; r < 20 && rx_valid === 1'b1; r++)
			take(reply);
		`CHK(r, QD + RXBUF_DEPTH)
		status_clear = 1;
		tick(1);
		status_clear = 0;
		tick(1);
		`CHK({status.rx_overflow, wake_request}, 2'b00)
		// Slave role wakes on select change
		cfg.master = 0;
		wcfg(1);
		`CHK(pad_oe, 4'h1)
		tb_ss = 0;
		for (k = 0; k < 500 && ss_wake !== 1'b1; k++)
			tick(1);
		to_chk;
		`CHK(wake_request, 1'b1)
		tb_ss = 1;
		tick(5);
		test_done;
	end
endmodule
`default_nettype wire
